// file: sicc_ctrl.sv
// decision and stamp logic for interrupt complete-split queue head visits
module sicc_ctrl #(
	parameter int UF = sicc_pkg::UFRAMES,
	parameter int FW = sicc_pkg::FRIDX_W,
	parameter int SW = sicc_pkg::STAMP_W
) (
	input wire logic core_clk,
	input wire logic reset,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// frame index counter from the host controller
	input wire logic [FW-1:0] frame_index_counter,
	input wire logic recovery_mode,
	// queue head visit presented by the schedule walker
	input wire logic visit,
	input wire logic phase_entry,
	input wire logic in_complete_phase,
	input wire logic token_direction,
	input wire logic qh_active,
	input wire logic qh_halted,
	input wire logic qh_inactivate,
	input wire logic [UF-1:0] smask,
	input wire logic [UF-1:0] cmask,
	input wire logic [UF-1:0] cprog,
	input wire logic [SW-1:0] hframe_stamp,
	// decision for the walker
	output logic done,
	output logic [2:0] action,
	output logic clear_active,
	output logic set_halted,
	output logic set_missed_uframe,
	output logic issue_start_split,
	output logic issue_complete_split,
	output logic [UF-1:0] next_cprog,
	output logic stamp_write,
	output logic [SW-1:0] next_hframe_stamp,
	output logic advance_queue
);
	logic [31:0] ctrl;
	logic [UF-1:0] current_uframe_onehot;
	logic [SW-1:0] index_hframe;
	logic test_a;
	logic test_b;
	logic test_c;
	logic test_d;
	logic raw_start_due;
	logic enabled;
	logic recov_apply;
	sicc_pkg::sicc_action_e next_action;
	logic [2:0] last_action;
	logic [15:0] miss_count;
	logic apb_wr;

	assign index_hframe = frame_index_counter[7:3];
	assign current_uframe_onehot = UF'(1) << frame_index_counter[2:0];
	assign enabled = ctrl[sicc_pkg::CTRL_EN];
	assign recov_apply = ctrl[sicc_pkg::CTRL_RECOV_APPLY];
	assign raw_start_due = |(current_uframe_onehot & smask);

	sicc_tests #(
		.UF(UF),
		.SW(SW)
	) u_tests (
		.current_uframe_onehot(current_uframe_onehot),
		.cmask(cmask),
		.smask(smask),
		.cprog(cprog),
		.hframe_stamp(hframe_stamp),
		.index_hframe(index_hframe),
		.recovery_mode(recovery_mode),
		.test_a(test_a),
		.test_b(test_b),
		.test_c(test_c),
		.test_d(test_d)
	);

	// decision table
	always_comb begin
		next_action = sicc_pkg::SICC_ACT_NONE;
		if (!enabled) begin
			next_action = sicc_pkg::SICC_ACT_NONE;
		end else if (qh_inactivate && !qh_active) begin
			next_action = sicc_pkg::SICC_ACT_NONE;
		end else if (qh_halted || !qh_active) begin
			next_action = sicc_pkg::SICC_ACT_NONE;
		end else if (qh_inactivate && !in_complete_phase) begin
			next_action = sicc_pkg::SICC_ACT_INACTIVATE;
		end else if (!in_complete_phase) begin
			if (raw_start_due && !recovery_mode) begin
				next_action = sicc_pkg::SICC_ACT_RETRY_SS;
			end else begin
				next_action = sicc_pkg::SICC_ACT_IGNORE;
			end
		end else if (recovery_mode && !recov_apply) begin
			next_action = sicc_pkg::SICC_ACT_DEFER;
		end else if (!test_a && !test_d) begin
			next_action = sicc_pkg::SICC_ACT_IGNORE;
		end else if (test_d || !test_c || !test_b) begin
			next_action = token_direction ? sicc_pkg::SICC_ACT_HALT
				: sicc_pkg::SICC_ACT_RETRY_SS;
		end else begin
			next_action = sicc_pkg::SICC_ACT_EXEC_CS;
		end
	end

	// outputs registered one cycle after the visit
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			done <= 1'b0;
			action <= 3'h0;
			clear_active <= 1'b0;
			set_halted <= 1'b0;
			set_missed_uframe <= 1'b0;
			issue_start_split <= 1'b0;
			issue_complete_split <= 1'b0;
			next_cprog <= '0;
			advance_queue <= 1'b0;
		end else begin
			done <= visit;
			action <= visit ? next_action : sicc_pkg::SICC_ACT_NONE;
			clear_active <= visit && (next_action == sicc_pkg::SICC_ACT_INACTIVATE
				|| next_action == sicc_pkg::SICC_ACT_HALT);
			set_halted <= visit && next_action == sicc_pkg::SICC_ACT_HALT;
			// retry in complete phase is a miss; in start phase it is the normal start
			set_missed_uframe <= visit && in_complete_phase
				&& (next_action == sicc_pkg::SICC_ACT_HALT
				|| next_action == sicc_pkg::SICC_ACT_RETRY_SS);
			// start-split only from the start phase and never in recovery mode
			issue_start_split <= visit && !in_complete_phase && !recovery_mode
				&& next_action == sicc_pkg::SICC_ACT_RETRY_SS;
			issue_complete_split <= visit && next_action == sicc_pkg::SICC_ACT_EXEC_CS;
			next_cprog <= (visit && next_action == sicc_pkg::SICC_ACT_EXEC_CS)
				? (cprog | current_uframe_onehot) : cprog;
			advance_queue <= visit && next_action == sicc_pkg::SICC_ACT_EXEC_CS;
		end
	end

	// stamp maintenance on phase entry or stay
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			stamp_write <= 1'b0;
			next_hframe_stamp <= '0;
		end else begin
			stamp_write <= visit && (phase_entry || in_complete_phase);
			if (visit && phase_entry && frame_index_counter[2:0] == sicc_pkg::ENTRY_ROLL_UF) begin
				next_hframe_stamp <= index_hframe + SW'(1);
			end else if (visit && !phase_entry && in_complete_phase
				&& frame_index_counter[2:0] == sicc_pkg::STAY_ROLL_UF) begin
				next_hframe_stamp <= index_hframe + SW'(1);
			end else if (visit) begin
				next_hframe_stamp <= index_hframe;
			end
		end
	end

	// apb slave, zero wait states
	assign pready = 1'b1;
	assign pslverr = 1'b0;
	assign apb_wr = psel && penable && pwrite;

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			ctrl <= sicc_pkg::CTRL_RESET;
		end else if (apb_wr && paddr == sicc_pkg::OFF_CTRL) begin
			ctrl <= {30'h0, pwdata[1:0]};
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			last_action <= 3'h0;
		end else if (visit) begin
			last_action <= next_action;
		end
	end

	// missed micro-frame counter; write clears, a miss in the same cycle wins
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			miss_count <= 16'h0000;
		end else if (set_missed_uframe) begin
			miss_count <= miss_count + 16'h0001;
		end else if (apb_wr && paddr == sicc_pkg::OFF_COUNT) begin
			miss_count <= 16'h0000;
		end
	end

	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			case (paddr)
				sicc_pkg::OFF_CTRL: prdata <= ctrl;
				sicc_pkg::OFF_STATUS: prdata <= {26'h0, recovery_mode, test_d, test_c,
					test_b, test_a, enabled};
				sicc_pkg::OFF_LAST: prdata <= {29'h0, last_action};
				sicc_pkg::OFF_COUNT: prdata <= {16'h0, miss_count};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end

	a_ignore_quiet: assert property (@(posedge core_clk) disable iff (reset)
		visit && enabled && qh_active && !qh_halted && in_complete_phase && !recovery_mode
		&& !test_a && !test_d |=> action == sicc_pkg::SICC_ACT_IGNORE
		&& !clear_active && !issue_complete_split)
		else $error("ignore case took action");
	a_miss_in_halt: assert property (@(posedge core_clk) disable iff (reset)
		visit && enabled && qh_active && !qh_halted && !qh_inactivate && in_complete_phase
		&& !recovery_mode && test_a && !test_c && token_direction
		|=> set_halted && set_missed_uframe)
		else $error("missed progress did not halt IN");
	a_tag_retry_out: assert property (@(posedge core_clk) disable iff (reset)
		visit && enabled && qh_active && !qh_halted && !qh_inactivate && in_complete_phase
		&& !recovery_mode && test_a && test_c && !test_b && !token_direction
		|=> action == sicc_pkg::SICC_ACT_RETRY_SS && set_missed_uframe && !set_halted)
		else $error("stamp miss did not retry OUT");
	a_exec_cs: assert property (@(posedge core_clk) disable iff (reset)
		issue_complete_split |-> $past(test_a) && $past(test_b) && $past(test_c)
		&& !$past(test_d))
		else $error("complete-split without passing tests");
	a_d_miss: assert property (@(posedge core_clk) disable iff (reset)
		visit && enabled && qh_active && !qh_halted && !qh_inactivate && in_complete_phase
		&& !recovery_mode && test_d |=> set_missed_uframe)
		else $error("test D did not flag miss");
	a_no_recov_ss: assert property (@(posedge core_clk) disable iff (reset)
		issue_start_split |-> !$past(recovery_mode))
		else $error("start-split in recovery mode");
	a_stamp_entry: assert property (@(posedge core_clk) disable iff (reset)
		visit && phase_entry && frame_index_counter[2:0] == 3'h6
		|=> next_hframe_stamp == $past(frame_index_counter[7:3]) + 5'h01)
		else $error("entry stamp not incremented");
	a_stamp_stay: assert property (@(posedge core_clk) disable iff (reset)
		visit && !phase_entry && in_complete_phase && frame_index_counter[2:0] == 3'h3
		|=> next_hframe_stamp == $past(frame_index_counter[7:3]))
		else $error("stay stamp wrong");
	a_inact_clear: assert property (@(posedge core_clk) disable iff (reset)
		visit && enabled && qh_inactivate && qh_active && !qh_halted && !in_complete_phase
		|=> clear_active && !issue_start_split)
		else $error("inactivate did not clear Active");
	a_halted_idle: assert property (@(posedge core_clk) disable iff (reset)
		visit && (qh_halted || (qh_inactivate && !qh_active))
		|=> !advance_queue && !clear_active && !issue_start_split)
		else $error("halted or inactive queue head advanced");
endmodule : sicc_ctrl

// file: sicc_pkg.sv
// shared constants for the split interrupt complete-split control block
package sicc_pkg;
	localparam int UFRAMES = 8;
	localparam int FRIDX_W = 14;
	localparam int STAMP_W = 5;
	// low field value on phase entry that rolls the stamp
	localparam logic [2:0] ENTRY_ROLL_UF = 3'h6;
	// low field value while staying that rolls the stamp
	localparam logic [2:0] STAY_ROLL_UF = 3'h7;
	// apb register offsets
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [7:0] OFF_LAST = 8'h08;
	localparam logic [7:0] OFF_COUNT = 8'h0C;
	// ctrl field positions
	localparam int CTRL_EN = 0;
	localparam int CTRL_RECOV_APPLY = 1;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	typedef enum logic [2:0] {
		SICC_ACT_NONE,
		SICC_ACT_IGNORE,
		SICC_ACT_HALT,
		SICC_ACT_RETRY_SS,
		SICC_ACT_EXEC_CS,
		SICC_ACT_INACTIVATE,
		SICC_ACT_DEFER
	} sicc_action_e;
endpackage : sicc_pkg

// file: sicc_tests.sv
// combinational scheduling tests A, B, C and D for one queue head
module sicc_tests #(
	parameter int UF = 8,
	parameter int SW = 5
) (
	input wire logic [UF-1:0] current_uframe_onehot,
	input wire logic [UF-1:0] cmask,
	input wire logic [UF-1:0] smask,
	input wire logic [UF-1:0] cprog,
	input wire logic [SW-1:0] hframe_stamp,
	input wire logic [SW-1:0] index_hframe,
	input wire logic recovery_mode,
	output logic test_a,
	output logic test_b,
	output logic test_c,
	output logic test_d
);
	logic [UF-1:0] prev_bit;
	assign prev_bit = {current_uframe_onehot[0], current_uframe_onehot[UF-1:1]};
	assign test_a = |(current_uframe_onehot & cmask);
	assign test_b = (hframe_stamp == index_hframe);
	// fails if previous slot scheduled but not done, or current slot already done
	assign test_c = !(|(prev_bit & cmask) && !(|(prev_bit & cprog)))
		&& !(|(current_uframe_onehot & cprog));
	assign test_d = |(current_uframe_onehot & smask) && !recovery_mode;
endmodule : sicc_tests

// file: sicc_sw_model.sv
// model of the software that owns the queue head status bits and stamp
module sicc_sw_model (
	input wire logic core_clk,
	input wire logic reset,
	input wire logic done,
	input wire logic sw_inact,
	input wire logic clear_active,
	input wire logic set_halted,
	input wire logic stamp_write,
	input wire logic [4:0] next_hframe_stamp,
	output logic qh_active,
	output logic qh_halted,
	output logic qh_inactivate,
	output logic [4:0] hframe_stamp
);
	logic [4:0] saved;
	// software acts only in the cycle after a decision, never during a visit
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			{qh_active, qh_halted, qh_inactivate} <= 3'h4;
		end else if (done) begin
			if (clear_active)
				{qh_active, qh_halted} <= {1'h0, set_halted};
			else if (sw_inact && qh_active && !qh_halted) begin
				saved <= hframe_stamp;
				qh_inactivate <= 1'h1;
			end else if (qh_inactivate && !qh_active && !qh_halted)
				qh_halted <= 1'h1;
			else if (qh_inactivate && qh_halted)
				qh_inactivate <= 1'h0;
			else if (!qh_active)
				{qh_active, qh_halted} <= 2'h2;
		end
	end
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset)
			hframe_stamp <= 5'h00;
		else if (done && stamp_write)
			hframe_stamp <= next_hframe_stamp;
	end
endmodule : sicc_sw_model

// file: testbench.sv
// self-checking bench for the interrupt complete-split decision block
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk, reset, psel, penable, pwrite, visit, phase_entry, in_complete_phase;
	logic token_direction, recovery_mode, sw_inact, pready, pslverr, done, clear_active;
	logic set_halted, set_missed_uframe, issue_start_split, issue_complete_split;
	logic stamp_write, advance_queue, qh_active, qh_halted, qh_inactivate, en, apply;
	logic [7:0] paddr, smask, cmask, cprog, next_cprog;
	logic [31:0] pwdata, prdata, rd;
	logic [13:0] frame_index_counter;
	logic [2:0] action, last_act;
	logic [4:0] hframe_stamp, next_hframe_stamp;
	int bad_count = 0;
	int n_checks = 0;
	int cycles = 0;
	int misses = 0;
	int seed = 32'h10ad;
	sicc_ctrl i_dut (.*);
	sicc_sw_model i_sw (.*);
	initial begin
		core_clk = 1'h0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("FAIL %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic print_verdict();
		if (bad_count == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		{psel, penable, pwrite} <= {2'h2, wr};
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'h1 && n < 40);
		rd = prdata;
		chk(pready, 1'h1);
		chk(pslverr, 1'h0);
		{psel, penable} <= 2'h0;
		if (n == 40)
			bad_count++;
	endtask : apb
	function automatic logic [2:0] f_act(input logic [7:0] o, s, c, p,
		input logic dir, rec, inc, input logic [4:0] st, h);
		logic a, b, cc, d;
		a = (o & c) != 0;
		b = st == h;
		cc = !(({o[0], o[7:1]} & c) != 0 && ({o[0], o[7:1]} & p) == 0) && (o & p) == 0;
		d = (o & s) != 0 && !rec;
		if (!en || qh_halted || !qh_active)
			return sicc_pkg::SICC_ACT_NONE;
		if (!inc && qh_inactivate)
			return sicc_pkg::SICC_ACT_INACTIVATE;
		if (!inc)
			return d ? sicc_pkg::SICC_ACT_RETRY_SS : sicc_pkg::SICC_ACT_IGNORE;
		if (rec && !apply)
			return sicc_pkg::SICC_ACT_DEFER;
		if (!a && !d)
			return sicc_pkg::SICC_ACT_IGNORE;
		if (d || !cc || !b)
			return dir ? sicc_pkg::SICC_ACT_HALT : sicc_pkg::SICC_ACT_RETRY_SS;
		return sicc_pkg::SICC_ACT_EXEC_CS;
	endfunction : f_act
	task automatic do_visit(input logic entry, input logic full);
		logic [13:0] fi;
		logic [7:0] o, s, c, p;
		logic dir, rec, inc, hl, hit, mis;
		logic [2:0] ex;
		logic [4:0] st;
		@(posedge core_clk);
		#1;
		fi = frame_index_counter + 14'($random(seed) & 3);
		o = 8'h01 << fi[2:0];
		hit = qh_inactivate && qh_active;
		s = hit ? smask : 8'($random(seed));
		c = hit ? cmask : 8'($random(seed));
		p = 1'($random(seed)) ? 8'($random(seed)) : (c & (o - 8'h01));
		dir = 1'($random(seed));
		rec = !apply || (($random(seed) & 3) == 0);
		inc = entry || (1'($random(seed)) && !qh_inactivate);
		hl = qh_halted || qh_inactivate;
		ex = f_act(o, s, c, p, dir, rec, inc, hframe_stamp, fi[7:3]);
		st = fi[7:3] + ((entry ? fi[2:0] == 3'h6 : fi[2:0] == 3'h7) ? 5'h01 : 5'h00);
		mis = inc && (ex == sicc_pkg::SICC_ACT_HALT || ex == sicc_pkg::SICC_ACT_RETRY_SS);
		@(posedge core_clk);
		{visit, phase_entry, in_complete_phase, token_direction} <= {1'h1, entry, inc, dir};
		{recovery_mode, frame_index_counter, smask, cmask, cprog} <= {rec, fi, s, c, p};
		sw_inact <= ($random(seed) & 7) == 0;
		@(posedge core_clk);
		visit <= 1'h0;
		#1;
		chk(done, 1'h1);
		chk(issue_start_split, !inc && ex == sicc_pkg::SICC_ACT_RETRY_SS);
		if (hl)
			chk(advance_queue, 1'h0);
		if (en)
			chk(stamp_write, entry || inc);
		if (en && (entry || inc))
			chk(next_hframe_stamp, st);
		if (!full || entry)
			return;
		chk(action, ex);
		chk(issue_complete_split, ex == sicc_pkg::SICC_ACT_EXEC_CS);
		chk(advance_queue, ex == sicc_pkg::SICC_ACT_EXEC_CS);
		chk(set_missed_uframe, mis);
		chk(set_halted, ex == sicc_pkg::SICC_ACT_HALT);
		chk(clear_active, ex == sicc_pkg::SICC_ACT_HALT || ex == sicc_pkg::SICC_ACT_INACTIVATE);
		chk(next_cprog, ex == sicc_pkg::SICC_ACT_EXEC_CS ? (p | o) : p);
		misses += int'(mis);
		last_act = ex;
	endtask : do_visit
	initial begin
		{psel, penable, pwrite, visit, phase_entry, in_complete_phase} = 6'h00;
		{token_direction, recovery_mode, sw_inact, last_act} = 6'h00;
		{paddr, smask, cmask, cprog} = 32'h0;
		pwdata = 32'h0;
		frame_index_counter = 14'h0000;
		{en, apply, reset} = 3'h5;
		repeat (8) @(posedge core_clk);
		reset <= 1'h0;
		#1;
		chk({done, action, clear_active, stamp_write}, 6'h00);
		apb(1'h0, sicc_pkg::OFF_CTRL, 32'h0);
		chk(rd, sicc_pkg::CTRL_RESET);
		apb(1'h1, 8'h10, 32'hFFFF_FFFF);
		apb(1'h0, 8'h10, 32'h0);
		chk(rd, 32'h0);
		apb(1'h1, sicc_pkg::OFF_CTRL, 32'h3);
		apply = 1'h1;
		repeat (400) do_visit(1'h0, 1'h1);
		apb(1'h0, sicc_pkg::OFF_COUNT, 32'h0);
		chk(rd, misses);
		apb(1'h0, sicc_pkg::OFF_LAST, 32'h0);
		chk(rd, last_act);
		apb(1'h1, sicc_pkg::OFF_COUNT, 32'h0);
		apb(1'h0, sicc_pkg::OFF_COUNT, 32'h0);
		chk(rd, 32'h0);
		repeat (40) do_visit(1'h1, 1'h1);
		apb(1'h1, sicc_pkg::OFF_CTRL, 32'h0);
		en = 1'h0;
		repeat (5) do_visit(1'h0, 1'h1);
		apb(1'h1, sicc_pkg::OFF_CTRL, 32'h1);
		{en, apply} = 2'h2;
		repeat (30) do_visit(1'h0, 1'h1);
		print_verdict();
	end
endmodule : testbench
